// >>> core/epio_pkg.sv
/*
 * constants for the emulated parallel i/o port: byte addresses in i/o space,
 * field positions and reset values.
 * assumes a host i/o bus that presents full 32-bit byte addresses.
 */
package epio_pkg;

	localparam int          ADDR_W         = 32;
	localparam int          DATA_W         = 8;
	localparam int          PIN_IN_W       = 3;

	localparam logic [31:0] PORT_C_DATA    = 32'h0000_0844;
	localparam logic [31:0] PORT_B_DATA    = 32'h0000_0845;
	localparam logic [31:0] PORT_A_DATA    = 32'h0000_0846;
	localparam logic [31:0] PORT_CONTROL   = 32'h0000_0847;

	localparam int          PORT_A_BIT6    = 6;
	localparam int          PORT_B_BIT7    = 7;
	localparam int          PORT_C_BIT2    = 2;
	localparam int          PORT_C_BIT3    = 3;

	localparam logic [7:0]  PORT_A_MASK    = 8'h40;
	localparam logic [7:0]  PORT_B_MASK    = 8'h80;
	localparam logic [7:0]  PORT_C_MASK    = 8'h0C;

	localparam logic [7:0]  RST_PORT_A     = 8'h00;
	localparam logic [7:0]  RST_CONTROL    = 8'h00;
	localparam logic [7:0]  RST_RDATA      = 8'h00;
	localparam logic [2:0]  RST_PINS       = 3'h1;

	typedef enum logic [1:0] {
		EPIO_SEL_C,
		EPIO_SEL_B,
		EPIO_SEL_A,
		EPIO_SEL_CTRL
	} epio_sel_t;

endpackage : epio_pkg

// >>> core/epio_sync.sv
/*
 * two flip-flop synchroniser, one lane per input bit.
 * assumes inputs are asynchronous pins; clk_en freezes both stages.
 */
`timescale 1ns/10ps
`default_nettype none

module epio_sync #(
	parameter int         WIDTH    = 3,
	parameter logic [2:0] RST_VAL  = 3'h0
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = meta;
		next_sync = pin_sync;
		if (clk_en) begin
			next_meta = pin_in;
			next_sync = meta;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta[i]     <= RST_VAL[i];
					pin_sync[i] <= RST_VAL[i];
				end else begin
					meta[i]     <= next_meta[i];
					pin_sync[i] <= next_sync[i];
				end
			end
		end
	endgenerate

endmodule : epio_sync

`default_nettype wire

// >>> core/epio_port.sv
/*
 * emulated parallel i/o port: three port data registers and a control
 * register at four consecutive i/o byte addresses, board-fail drive,
 * abort status and module-type straps.
 * assumes one-cycle read/write strobes on clk from the host i/o decoder;
 * abort and strap pins are asynchronous and are synchronised here.
 */
// Function
// - decode four byte addresses: port C, port B, port A, then control
// - no pseudo interrupt acknowledge; accesses have no hidden side effects
// - port bit directions fixed; control writes never change direction
// - port A bit 6 is output; setting it drives board fail active
// - port B bit 7 input returns current active-low abort level
// - port C bits 2,3 report two-bit base module type code
// - no isa dma channels; no request or acknowledge logic
`timescale 1ns/10ps
`default_nettype none

module epio_port (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [31:0] io_addr,
	input  wire logic        io_rd,
	input  wire logic        io_wr,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_ack,
	input  wire logic        abort_n,
	input  wire logic        module_type_bit0,
	input  wire logic        module_type_bit1,
	output logic             board_fail_out,
	output logic             fail_lamp,
	output logic      [7:0]  port_control
);

	logic [2:0]        pins_sync;
	logic              abort_sync_n;
	logic [1:0]        type_sync;
	logic              hit;
	epio_pkg::epio_sel_t sel;
	logic [7:0]        rd_value;
	logic [7:0]        port_a_data;
	logic [7:0]        next_port_a_data;
	logic [7:0]        next_port_control;
	logic [7:0]        next_io_rdata;
	logic              next_io_ack;

	epio_sync #(
		.WIDTH   (3),
		.RST_VAL (epio_pkg::RST_PINS)
	) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.pin_in   ({module_type_bit1, module_type_bit0, abort_n}),
		.pin_sync (pins_sync)
	);

	assign abort_sync_n = pins_sync[0];
	assign type_sync    = pins_sync[2:1];

	// address decode; only these four bytes answer, nothing for dma
	always_comb begin
		hit = 1'b1;
		sel = epio_pkg::EPIO_SEL_C;
		case (io_addr)
			epio_pkg::PORT_C_DATA:  sel = epio_pkg::EPIO_SEL_C;
			epio_pkg::PORT_B_DATA:  sel = epio_pkg::EPIO_SEL_B;
			epio_pkg::PORT_A_DATA:  sel = epio_pkg::EPIO_SEL_A;
			epio_pkg::PORT_CONTROL: sel = epio_pkg::EPIO_SEL_CTRL;
			default:                hit = 1'b0;
		endcase
	end

	// read mux; unassigned bits masked to zero
	always_comb begin
		rd_value = 8'h00;
		case (sel)
			epio_pkg::EPIO_SEL_C: begin
				rd_value[epio_pkg::PORT_C_BIT2] = type_sync[0];
				rd_value[epio_pkg::PORT_C_BIT3] = type_sync[1];
			end
			epio_pkg::EPIO_SEL_B: begin
				rd_value[epio_pkg::PORT_B_BIT7] = abort_sync_n;
			end
			epio_pkg::EPIO_SEL_A: begin
				rd_value = port_a_data & epio_pkg::PORT_A_MASK;
			end
			epio_pkg::EPIO_SEL_CTRL: begin
				rd_value = port_control;
			end
			default: begin
				rd_value = 8'h00;
			end
		endcase
	end

	// reads only sample; ack and read data are registered, no port state change on read
	always_comb begin
		next_port_a_data  = port_a_data;
		next_port_control = port_control;
		next_io_rdata     = io_rdata;
		next_io_ack       = io_ack;
		if (clk_en) begin
			next_io_ack   = hit && (io_rd || io_wr);
			next_io_rdata = (hit && io_rd) ? rd_value : 8'h00;
			if (hit && io_wr && sel == epio_pkg::EPIO_SEL_A) begin
				next_port_a_data = io_wdata & epio_pkg::PORT_A_MASK;
			end
			if (hit && io_wr && sel == epio_pkg::EPIO_SEL_CTRL) begin
				next_port_control = io_wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			port_a_data    <= epio_pkg::RST_PORT_A;
			port_control   <= epio_pkg::RST_CONTROL;
			io_rdata       <= epio_pkg::RST_RDATA;
			io_ack         <= 1'b0;
			board_fail_out <= 1'b0;
			fail_lamp      <= 1'b0;
		end else begin
			port_a_data    <= next_port_a_data;
			port_control   <= next_port_control;
			io_rdata       <= next_io_rdata;
			io_ack         <= next_io_ack;
			// fixed output: the control register is not consulted
			board_fail_out <= next_port_a_data[epio_pkg::PORT_A_BIT6];
			fail_lamp      <= next_port_a_data[epio_pkg::PORT_A_BIT6];
		end
	end

	wire logic acc    = clk_en && (io_rd || io_wr);
	wire logic rd_c   = clk_en && io_rd && io_addr == epio_pkg::PORT_C_DATA;
	wire logic rd_b   = clk_en && io_rd && io_addr == epio_pkg::PORT_B_DATA;
	wire logic rd_a   = clk_en && io_rd && io_addr == epio_pkg::PORT_A_DATA;
	wire logic wr_a   = clk_en && io_wr && io_addr == epio_pkg::PORT_A_DATA;
	wire logic wr_ctl = clk_en && io_wr && !io_rd && io_addr == epio_pkg::PORT_CONTROL;
	wire logic in_rng = io_addr >= epio_pkg::PORT_C_DATA
		&& io_addr <= epio_pkg::PORT_CONTROL;

	chk_decode_ack:
	assert property (@(posedge clk) disable iff (sys_rst)
		acc && in_rng |=> io_ack)
		else $error("mapped access not acknowledged");

	chk_unmapped_quiet:
	assert property (@(posedge clk) disable iff (sys_rst)
		acc && !in_rng |=> !io_ack && io_rdata == 8'h00)
		else $error("unmapped access answered");

	chk_read_no_effect:
	assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && io_rd && !io_wr |=> $stable(board_fail_out) && $stable(port_control))
		else $error("read changed port state");

	chk_ctrl_no_dir:
	assert property (@(posedge clk) disable iff (sys_rst)
		wr_ctl |=> $stable(board_fail_out) && port_control == $past(io_wdata))
		else $error("control write disturbed output or not stored");

	chk_fail_drive:
	assert property (@(posedge clk) disable iff (sys_rst)
		wr_a |=> board_fail_out == $past(io_wdata[6]) && fail_lamp == board_fail_out)
		else $error("board fail does not follow port a bit 6");

	chk_abort_read:
	assert property (@(posedge clk) disable iff (sys_rst)
		rd_b |=> io_rdata == {$past(abort_sync_n), 7'h00})
		else $error("port b read wrong");

	chk_type_read:
	assert property (@(posedge clk) disable iff (sys_rst)
		rd_c |=> io_rdata == {4'h0, $past(type_sync), 2'h0})
		else $error("port c read wrong");

	chk_unused_zero:
	assert property (@(posedge clk) disable iff (sys_rst)
		rd_a |=> (io_rdata & ~epio_pkg::PORT_A_MASK) == 8'h00
			&& io_rdata[6] == $past(board_fail_out))
		else $error("port a unused bits not zero");

	cov_fail_on: cover property (@(posedge clk) disable iff (sys_rst)
		wr_a && io_wdata[6] ##1 board_fail_out);
	cov_abort_low: cover property (@(posedge clk) disable iff (sys_rst)
		rd_b ##1 !io_rdata[7]);
	cov_type_new: cover property (@(posedge clk) disable iff (sys_rst)
		rd_c ##1 io_rdata[3:2] == 2'h0);
	cov_ctrl_write: cover property (@(posedge clk) disable iff (sys_rst)
		wr_ctl ##1 io_ack);

endmodule : epio_port

`default_nettype wire

// >>> tb/epio_board.sv
/*
 * board-side model of the port's far side: fail lamp, abort switch, type straps.
 * assumes the bench commands the switch and the strap code.
 */
`timescale 1ns/10ps
`default_nettype none

module epio_board (
	input  wire logic       fail_lamp,
	input  wire logic       abort_press,
	input  wire logic [1:0] type_code,
	output logic            abort_n,
	output logic            module_type_bit0,
	output logic            module_type_bit1,
	output logic            lamp_lit
);
	// switch pulls the line low while pressed
	assign abort_n          = ~abort_press;
	assign module_type_bit0 = type_code[0];
	assign module_type_bit1 = type_code[1];
	assign lamp_lit         = fail_lamp;
endmodule : epio_board

`default_nettype wire

// >>> tb/epio_port_tb_top.sv
/*
 * self-checking bench for the parallel i/o port with the board model.
 * assumes one-cycle strobes, reply registered on the taking edge itself.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module epio_port_tb_top;
	logic        clk, sys_rst, clk_en, io_rd, io_wr, io_ack, abort_press, lamp_lit;
	logic        board_fail_out, fail_lamp, abort_n, type0, type1;
	logic [31:0] io_addr;
	logic [7:0]  io_wdata, io_rdata, port_control, v, front;
	logic [1:0]  type_code;
	logic [7:0]  exp_q[$];
	logic [31:0] bad_addr[3] = '{32'h0000_0843, 32'h0000_0848, 32'h0001_0846};
	int          seed, miscompares, n_tests, cycles;

	epio_port u_epio_port (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_ack(io_ack), .abort_n(abort_n),
		.module_type_bit0(type0), .module_type_bit1(type1),
		.board_fail_out(board_fail_out), .fail_lamp(fail_lamp),
		.port_control(port_control));
	epio_board u_epio_board (.fail_lamp(fail_lamp), .abort_press(abort_press),
		.type_code(type_code), .abort_n(abort_n), .module_type_bit0(type0),
		.module_type_bit1(type1), .lamp_lit(lamp_lit));

	always #20 clk = ~clk;

	task results;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// one access per call; strobes stay up for back-to-back calls
	task acc(input logic rd, input logic wr, input logic [31:0] a, input logic [7:0] d,
		input logic [7:0] e);
		io_rd = rd;
		io_wr = wr;
		io_addr = a;
		io_wdata = d;
		if (clk_en && a >= epio_pkg::PORT_C_DATA && a <= epio_pkg::PORT_CONTROL)
			exp_q.push_back(e);
		@(negedge clk);
	endtask : acc

	task idle(input int n);
		io_rd = 1'b0;
		io_wr = 1'b0;
		repeat (n) @(negedge clk);
	endtask : idle

	always @(negedge clk) begin
		if (!sys_rst && clk_en) begin
			if (io_ack === 1'b1) begin
				front = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
				`CHK(io_rdata, front)
			end else begin
				`CHK(io_rdata, 8'h00)
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		seed = 43;
		clk = 1'b0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		abort_press = 1'b0;
		type_code = 2'h0;
		io_addr = 32'h0000_0000;
		io_wdata = 8'h00;
		idle(8);
		sys_rst = 1'b0;
		`CHK(board_fail_out, 1'b0)
		`CHK(port_control, epio_pkg::RST_CONTROL)
		acc(0, 1, epio_pkg::PORT_A_DATA, 8'hFF, 8'h00);
		acc(1, 0, epio_pkg::PORT_A_DATA, 8'h00, 8'h40);
		idle(1);
		`CHK(lamp_lit, 1'b1)
		repeat (4) begin
			v = 8'($random(seed));
			acc(0, 1, epio_pkg::PORT_CONTROL, v, 8'h00);
			acc(1, 0, epio_pkg::PORT_CONTROL, 8'h00, v);
			acc(1, 0, epio_pkg::PORT_CONTROL, 8'h00, v);
			idle(1);
			`CHK(port_control, v)
			`CHK(board_fail_out, 1'b1)
		end
		for (int i = 0; i < 4; i++) begin
			abort_press = i[0];
			type_code = i[1:0];
			idle(3);
			acc(0, 1, epio_pkg::PORT_B_DATA, 8'($random(seed)), 8'h00);
			acc(0, 1, epio_pkg::PORT_C_DATA, 8'($random(seed)), 8'h00);
			acc(1, 0, epio_pkg::PORT_B_DATA, 8'h00, {~i[0], 7'h00});
			acc(1, 0, epio_pkg::PORT_C_DATA, 8'h00, {4'h0, i[1:0], 2'h0});
		end
		foreach (bad_addr[k]) begin
			acc(0, 1, bad_addr[k], 8'h00, 8'h00);
			acc(1, 0, bad_addr[k], 8'h00, 8'h00);
		end
		idle(1);
		`CHK(board_fail_out, 1'b1)
		clk_en = 1'b0;
		acc(0, 1, epio_pkg::PORT_A_DATA, 8'h00, 8'h00);
		idle(2);
		clk_en = 1'b1;
		acc(1, 0, epio_pkg::PORT_A_DATA, 8'h00, 8'h40);
		// read and write together: old value back, new value stored
		acc(1, 1, epio_pkg::PORT_A_DATA, 8'h00, 8'h40);
		acc(0, 1, epio_pkg::PORT_A_DATA, 8'hBF, 8'h00);
		acc(1, 0, epio_pkg::PORT_A_DATA, 8'h00, 8'h00);
		idle(2);
		`CHK(fail_lamp, 1'b0)
		`CHK(exp_q.size(), 0)
		results();
	end
endmodule : epio_port_tb_top

`default_nettype wire
